// >>> logic/csd_regs.vh
// Constants for the 8-bit core datapath: status bits, address windows, vectors.
// Assumes it is included by bare name from the design files of this block.
`ifndef CSD_REGS_VH
`define CSD_REGS_VH

// ****************************************************************
// Status register fields
// ****************************************************************
`define CSD_ST_GIE 7
`define CSD_ST_CPY 6
`define CSD_ST_HC 5
`define CSD_ST_SGN 4
`define CSD_ST_OVF 3
`define CSD_ST_NEG 2
`define CSD_ST_ZER 1
`define CSD_ST_CAR 0
`define CSD_STATUS_RESET 8'h00

// ****************************************************************
// Data space windows
// ****************************************************************
`define CSD_IO_BASE 16'h0020
`define CSD_IO_LAST 16'h005F
`define CSD_XIO_BASE 16'h0060
`define CSD_XIO_LAST 16'h00FF
`define CSD_IO_STATUS 6'h3F
`define CSD_IO_COUNT 64

// ****************************************************************
// Pointer register indices and vector spacing
// ****************************************************************
`define CSD_PTR_X 5'h1A
`define CSD_PTR_Y 5'h1C
`define CSD_PTR_Z 5'h1E
`define CSD_VEC_SMALL 2'h1
`define CSD_VEC_LARGE 2'h2

// ****************************************************************
// Operation codes presented by the decoder
// ****************************************************************
`define CSD_OP_NOP 5'h00
`define CSD_OP_ADD 5'h01
`define CSD_OP_ADC 5'h02
`define CSD_OP_SUB 5'h03
`define CSD_OP_SBC 5'h04
`define CSD_OP_AND 5'h05
`define CSD_OP_OR 5'h06
`define CSD_OP_XOR 5'h07
`define CSD_OP_COM 5'h08
`define CSD_OP_NEG 5'h09
`define CSD_OP_INC 5'h0A
`define CSD_OP_DEC 5'h0B
`define CSD_OP_LSR 5'h0C
`define CSD_OP_MOV 5'h0D
`define CSD_OP_BST 5'h0E
`define CSD_OP_BLD 5'h0F
`define CSD_OP_SEI 5'h10
`define CSD_OP_CLI 5'h11
`define CSD_OP_INTERRUPT_RETURN_INSTR 5'h12
`define CSD_OP_CALL 5'h13
`define CSD_OP_SPM 5'h14
`define CSD_OP_IN 5'h15
`define CSD_OP_OUT 5'h16
`define CSD_OP_LDS 5'h17
`define CSD_OP_STS 5'h18
`define CSD_OP_CP 5'h19
`define CSD_OP_LDI 5'h1A

`endif

// >>> logic/csd_regfile.v
// Register file of 32 eight-bit working registers with two read ports.
// Assumes one write per clock; read data come out of registers, so the core
// presents read addresses one cycle ahead.
`timescale 1ns/10ps

module csd_regfile (
	// Clock
	input wire clk,
	// Read ports
	input wire [4:0] rd_addr_a,
	input wire [4:0] rd_addr_b,
	output reg [7:0] rd_data_a,
	output reg [7:0] rd_data_b,
	// Write port
	input wire wr_en,
	input wire [4:0] wr_addr,
	input wire [7:0] wr_data
);

reg [7:0] mem [0:31];

// ****************************************************************
// Storage
// ****************************************************************
// Write-through on a same-cycle hit keeps back-to-back operations correct.
always @(posedge clk) begin
	if (wr_en) begin
		mem[wr_addr] <= wr_data;
	end
	rd_data_a <= (wr_en && wr_addr == rd_addr_a) ? wr_data : mem[rd_addr_a];
	rd_data_b <= (wr_en && wr_addr == rd_addr_b) ? wr_data : mem[rd_addr_b];
end

endmodule // csd_regfile

// >>> logic/csd_core.v
// Datapath of the 8-bit core: pipeline, ALU, status flags, interrupt entry,
// pointer pairs, I/O windows and self-write guard.
// Assumes a program memory with one cycle of read latency and a data memory
// that accepts a write or read request in one cycle.
//
// Functional notes
// [RULE1] Next instruction is fetched while current one executes, one per cycle.
// [RULE2] Thirty-two eight-bit registers, each read or written in one cycle.
// [RULE3] Two operands read, result computed and written back in one cycle.
// [RULE4] Registers 26 to 31 form three 16-bit pointers; the last also reads flash. The core has no flash read and only drives ptr_z out.
// [RULE5] Status flags follow every ALU operation result.
// [RULE6] Status register is neither saved nor restored on interrupts.
// [RULE7] Bit 7 global enable clear blocks every interrupt.
// [RULE8] Taking an interrupt clears global enable; interrupt return sets it.
// [RULE9] Dedicated instructions set and clear global enable.
// [RULE10] Bit 6 copy cell: bit-store loads it, bit-load writes it out.
// [RULE11] Bit 5 flags carry out of the low nibble on add and subtract.
// [RULE12] Bit 4 always equals negative xor overflow. An OUT to the status address loads bit 4 straight from the register.
// [RULE13] Lowest-numbered pending vector is served first.
// [RULE14] Vector spacing is one word, or two in the largest memory size.
// [RULE15] With read-while-write, flash self-write runs only from boot section.
// [RULE16] 64 I/O addresses, direct or at data addresses 0x20 to 0x5F.
// [RULE17] Extended I/O 0x60 to 0xFF only by load and store, not short I/O.
// [RULE18] Decoder takes 16-bit and 32-bit instructions; most are one word.
// [RULE19] Calls and interrupt entry push the return address onto the stack; the core writes only its low byte.
// [RULE20] Flash has boot and application sections; app writes come from boot. The core allows them from anywhere when rww_variant is low.
// [RULE21] ALU works register-register, register-immediate and single-register.
// [RULE22] Bits 3 to 0: overflow, negative, zero, carry.
// [RULE23] Status register resets to zero, interrupts globally off.
`timescale 1ns/10ps
`include "csd_regs.vh"

module csd_core (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Variant straps
	input wire rww_variant,
	input wire large_flash,
	input wire [15:0] boot_start,
	// Program memory
	output reg [15:0] prog_addr,
	input wire [15:0] prog_data,
	// Decoded operation from the instruction word
	input wire [4:0] op_code,
	input wire [4:0] op_dst,
	input wire [4:0] op_src,
	input wire [7:0] op_imm,
	input wire op_use_imm,
	input wire [2:0] op_bit,
	input wire op_two_word,
	// Interrupt requests, bit 0 has the lowest vector
	input wire [15:0] irq_pending,
	output reg [3:0] irq_ack_num,
	output reg irq_ack,
	// Data memory
	output reg [15:0] data_addr,
	output reg [7:0] data_wdata,
	output reg data_we,
	output reg data_re,
	input wire [7:0] data_rdata,
	// Flash self-write and pointer
	output reg flash_write_go,
	output reg flash_write_refused,
	output wire [15:0] ptr_x,
	output wire [15:0] ptr_y,
	output wire [15:0] ptr_z,
	// Status register view
	output reg [7:0] processor_status_flags
);

// ****************************************************************
// Declarations
// ****************************************************************
localparam ST_RUN = 3'b001;
localparam ST_OPER = 3'b010;
localparam ST_PUSH = 3'b100;

reg [2:0] state_reg;
reg [15:0] pc_reg;
reg [15:0] exec_pc_reg;
reg [15:0] ret_reg;
reg [15:0] sp_reg;
reg [4:0] ra_addr;
reg [4:0] rb_addr;
reg wr_en;
reg [4:0] wr_addr;
reg [7:0] wr_data;
reg [7:0] st_next;
reg [7:0] res;
reg [8:0] sum;
reg [4:0] half;
reg alu_op;
reg [7:0] opnd_b;
reg [15:0] xreg_reg;
reg [15:0] yreg_reg;
reg [15:0] zreg_reg;
reg take_irq;
reg [4:0] dec_code_reg;
reg [4:0] dec_dst_reg;
reg [7:0] dec_imm_reg;
reg dec_use_imm_reg;
reg [2:0] dec_bit_reg;
reg dec_two_reg;
reg [4:0] oper_code_reg;
reg [7:0] oper_data_reg;
reg [3:0] irq_num;
reg in_boot;
wire [7:0] reg_a;
wire [7:0] reg_b;

// ****************************************************************
// Helper functions
// ****************************************************************
// Lowest set request wins, so the lowest vector address is served first.
function [3:0] csd_first;
	input [15:0] req;
	integer i;
	begin
		csd_first = 4'h0;
		for (i = 15; i >= 0; i = i - 1) begin
			if (req[i]) begin
				csd_first = i[3:0];
			end
		end
	end
endfunction

// Status word with the sign bit tied to negative xor overflow.
function [7:0] csd_flags;
	input [7:0] old;
	input [7:0] r;
	input h;
	input v;
	input c;
	begin
		csd_flags = old;
		csd_flags[`CSD_ST_HC] = h;
		csd_flags[`CSD_ST_OVF] = v;
		csd_flags[`CSD_ST_NEG] = r[7];
		csd_flags[`CSD_ST_ZER] = (r == 8'h00);
		csd_flags[`CSD_ST_CAR] = c;
		csd_flags[`CSD_ST_SGN] = r[7] ^ v;
	end
endfunction

// ****************************************************************
// Register file
// ****************************************************************
// [RULE2] [RULE3] single-cycle file
csd_regfile u_file (
	.clk(clk),
	.rd_addr_a(ra_addr),
	.rd_addr_b(rb_addr),
	.rd_data_a(reg_a),
	.rd_data_b(reg_b),
	.wr_en(wr_en),
	.wr_addr(wr_addr),
	.wr_data(wr_data)
);

// Operands are addressed from the decode stage, so data arrive at execute.
always @* begin
	ra_addr = op_dst;
	rb_addr = op_src;
end

// [RULE4] pointer pair views
assign ptr_x = xreg_reg;
assign ptr_y = yreg_reg;
assign ptr_z = zreg_reg;

// ****************************************************************
// ALU and next status
// ****************************************************************
// [RULE21] register, immediate or single operand
always @* begin
	opnd_b = dec_use_imm_reg ? dec_imm_reg : reg_b;
	res = reg_a;
	sum = 9'h000;
	half = 5'h00;
	alu_op = 1'b1;
	st_next = processor_status_flags;
	case (dec_code_reg)
		`CSD_OP_ADD, `CSD_OP_ADC: begin
			sum = {1'b0, reg_a} + {1'b0, opnd_b} +
				{8'h00, (dec_code_reg == `CSD_OP_ADC) & processor_status_flags[`CSD_ST_CAR]};
			half = {1'b0, reg_a[3:0]} + {1'b0, opnd_b[3:0]} +
				{4'h0, (dec_code_reg == `CSD_OP_ADC) & processor_status_flags[`CSD_ST_CAR]};
			res = sum[7:0];
			// [RULE11] [RULE12] [RULE22] add flags
			st_next = csd_flags(processor_status_flags, res, half[4],
				(reg_a[7] == opnd_b[7]) && (res[7] != reg_a[7]), sum[8]);
		end
		`CSD_OP_SUB, `CSD_OP_SBC, `CSD_OP_CP, `CSD_OP_NEG: begin
			sum = (dec_code_reg == `CSD_OP_NEG) ? {1'b0, 8'h00} - {1'b0, reg_a} :
				{1'b0, reg_a} - {1'b0, opnd_b} -
				{8'h00, (dec_code_reg == `CSD_OP_SBC) & processor_status_flags[`CSD_ST_CAR]};
			half = (dec_code_reg == `CSD_OP_NEG) ? 5'h00 - {1'b0, reg_a[3:0]} :
				{1'b0, reg_a[3:0]} - {1'b0, opnd_b[3:0]} -
				{4'h0, (dec_code_reg == `CSD_OP_SBC) & processor_status_flags[`CSD_ST_CAR]};
			res = (dec_code_reg == `CSD_OP_CP) ? reg_a : sum[7:0];
			// [RULE11] [RULE22] borrow flags
			st_next = csd_flags(processor_status_flags, sum[7:0], half[4],
				(dec_code_reg == `CSD_OP_NEG) ? (reg_a == 8'h80) :
				((reg_a[7] != opnd_b[7]) && (sum[7] != reg_a[7])), sum[8]);
		end
		`CSD_OP_AND, `CSD_OP_OR, `CSD_OP_XOR: begin
			res = (dec_code_reg == `CSD_OP_AND) ? (reg_a & opnd_b) :
				(dec_code_reg == `CSD_OP_OR) ? (reg_a | opnd_b) : (reg_a ^ opnd_b);
			st_next = csd_flags(processor_status_flags, res,
				processor_status_flags[`CSD_ST_HC], 1'b0,
				processor_status_flags[`CSD_ST_CAR]);
		end
		`CSD_OP_COM: begin
			res = ~reg_a;
			st_next = csd_flags(processor_status_flags, res,
				processor_status_flags[`CSD_ST_HC], 1'b0, 1'b1);
		end
		`CSD_OP_INC, `CSD_OP_DEC: begin
			res = (dec_code_reg == `CSD_OP_INC) ? reg_a + 8'h01 : reg_a - 8'h01;
			st_next = csd_flags(processor_status_flags, res,
				processor_status_flags[`CSD_ST_HC],
				(dec_code_reg == `CSD_OP_INC) ? (reg_a == 8'h7F) : (reg_a == 8'h80),
				processor_status_flags[`CSD_ST_CAR]);
		end
		`CSD_OP_LSR: begin
			res = {1'b0, reg_a[7:1]};
			st_next = csd_flags(processor_status_flags, res,
				processor_status_flags[`CSD_ST_HC], reg_a[0], reg_a[0]);
		end
		`CSD_OP_MOV, `CSD_OP_LDI: begin
			res = opnd_b;
			alu_op = 1'b0;
		end
		`CSD_OP_BST: begin
			// [RULE10] bit into copy cell
			st_next[`CSD_ST_CPY] = reg_a[dec_bit_reg];
			alu_op = 1'b0;
		end
		`CSD_OP_BLD: begin
			// [RULE10] copy cell into bit
			res[dec_bit_reg] = processor_status_flags[`CSD_ST_CPY];
			alu_op = 1'b0;
		end
		default: begin
			alu_op = 1'b0;
		end
	endcase
end

// [RULE3] write back in the execute cycle
// The file forwards this write to a read of the same register in the same
// cycle, so back-to-back dependent operations see the new value.
always @* begin
	wr_en = 1'b0;
	wr_addr = dec_dst_reg;
	wr_data = res;
	if (state_reg == ST_RUN && !take_irq && dec_code_reg != `CSD_OP_CP &&
		(alu_op || dec_code_reg == `CSD_OP_MOV || dec_code_reg == `CSD_OP_LDI ||
		dec_code_reg == `CSD_OP_BLD)) begin
		wr_en = 1'b1;
	end
end

// ****************************************************************
// Interrupt selection
// ****************************************************************
// [RULE7] [RULE13] gated, lowest vector first
always @* begin
	irq_num = csd_first(irq_pending);
	take_irq = (state_reg == ST_RUN) && processor_status_flags[`CSD_ST_GIE] &&
		(irq_pending != 16'h0000);
	in_boot = exec_pc_reg >= boot_start;
end

// ****************************************************************
// Pipeline, status and memory side effects
// ****************************************************************
// The fetch address runs one word ahead of the executing word, so the
// fetch of the next instruction overlaps the current execute.
always @(posedge clk) begin
	if (rst) begin
		state_reg <= ST_RUN;
		pc_reg <= 16'h0000;
		exec_pc_reg <= 16'h0000;
		ret_reg <= 16'h0000;
		sp_reg <= 16'hFFFF;
		prog_addr <= 16'h0000;
		// [RULE23] cleared status
		processor_status_flags <= `CSD_STATUS_RESET;
		dec_code_reg <= `CSD_OP_NOP;
		dec_dst_reg <= 5'h00;
		dec_imm_reg <= 8'h00;
		dec_use_imm_reg <= 1'b0;
		dec_bit_reg <= 3'h0;
		dec_two_reg <= 1'b0;
		oper_code_reg <= `CSD_OP_NOP;
		oper_data_reg <= 8'h00;
		xreg_reg <= 16'h0000;
		yreg_reg <= 16'h0000;
		zreg_reg <= 16'h0000;
		irq_ack <= 1'b0;
		irq_ack_num <= 4'h0;
		data_addr <= 16'h0000;
		data_wdata <= 8'h00;
		data_we <= 1'b0;
		data_re <= 1'b0;
		flash_write_go <= 1'b0;
		flash_write_refused <= 1'b0;
	end else begin
		// Decode stage; ops offered during an extra cycle are dropped.
		dec_code_reg <= (state_reg == ST_RUN && !take_irq) ? op_code : `CSD_OP_NOP;
		dec_dst_reg <= op_dst;
		dec_imm_reg <= op_imm;
		dec_use_imm_reg <= op_use_imm;
		dec_bit_reg <= op_bit;
		dec_two_reg <= (state_reg == ST_RUN && !take_irq) ? op_two_word : 1'b0;
		irq_ack <= 1'b0;
		data_we <= 1'b0;
		data_re <= 1'b0;
		flash_write_go <= 1'b0;
		flash_write_refused <= 1'b0;
		case (state_reg)
			ST_RUN: begin
				if (take_irq) begin
					// [RULE8] [RULE6] entry clears only the enable bit
					processor_status_flags[`CSD_ST_GIE] <= 1'b0;
					irq_ack <= 1'b1;
					irq_ack_num <= irq_num;
					ret_reg <= exec_pc_reg;
					// [RULE14] vector spacing by memory size
					pc_reg <= {11'h000, irq_num + 4'h1, 1'b0} >> (large_flash ? 0 : 1);
					prog_addr <= {11'h000, irq_num + 4'h1, 1'b0} >> (large_flash ? 0 : 1);
					state_reg <= ST_PUSH;
				end else begin
					// [RULE1] [RULE18] prefetch, two-word skip
					exec_pc_reg <= pc_reg;
					pc_reg <= pc_reg + (dec_two_reg ? 16'h0002 : 16'h0001);
					prog_addr <= pc_reg + (dec_two_reg ? 16'h0002 : 16'h0001);
					if (dec_two_reg) begin
						state_reg <= ST_OPER;
						oper_code_reg <= dec_code_reg;
						oper_data_reg <= reg_a;
					end
					// [RULE5] flags follow the executed operation
					processor_status_flags <= st_next;
					case (dec_code_reg)
						// [RULE9] dedicated enable controls
						`CSD_OP_SEI: processor_status_flags[`CSD_ST_GIE] <= 1'b1;
						`CSD_OP_CLI: processor_status_flags[`CSD_ST_GIE] <= 1'b0;
						// [RULE8] return re-enables
						`CSD_OP_INTERRUPT_RETURN_INSTR: processor_status_flags[`CSD_ST_GIE] <= 1'b1;
						`CSD_OP_CALL: begin
							ret_reg <= pc_reg + 16'h0001;
							state_reg <= ST_PUSH;
						end
						`CSD_OP_SPM: begin
							// [RULE15] [RULE20] boot-only self-write when rww_variant is set, allowed from anywhere otherwise
							flash_write_go <= !rww_variant || in_boot;
							flash_write_refused <= rww_variant && !in_boot;
						end
						`CSD_OP_IN, `CSD_OP_OUT: begin
							// [RULE16] short I/O maps above the file
							data_addr <= `CSD_IO_BASE + {10'h000, dec_imm_reg[5:0]};
							data_we <= (dec_code_reg == `CSD_OP_OUT);
							data_re <= (dec_code_reg == `CSD_OP_IN);
							data_wdata <= reg_a;
							if (dec_code_reg == `CSD_OP_OUT &&
								dec_imm_reg[5:0] == `CSD_IO_STATUS) begin
								processor_status_flags <= reg_a;
							end
						end
						default: begin
						end
					endcase
				end
			end
			ST_OPER: begin
				// [RULE17] extended I/O only via direct load/store
				data_addr <= prog_data;
				data_we <= (oper_code_reg == `CSD_OP_STS);
				data_re <= (oper_code_reg == `CSD_OP_LDS);
				data_wdata <= oper_data_reg;
				exec_pc_reg <= pc_reg;
				state_reg <= ST_RUN;
			end
			ST_PUSH: begin
				// [RULE19] low byte of return address to stack
				data_addr <= sp_reg;
				data_wdata <= ret_reg[7:0];
				data_we <= 1'b1;
				sp_reg <= sp_reg - 16'h0002;
				state_reg <= ST_RUN;
			end
			default: state_reg <= ST_RUN;
		endcase
		// [RULE4] pointer pairs track writes to the top six registers
		if (wr_en && wr_addr[4:1] == `CSD_PTR_X >> 1) begin
			if (wr_addr[0]) xreg_reg[15:8] <= wr_data; else xreg_reg[7:0] <= wr_data;
		end
		if (wr_en && wr_addr[4:1] == `CSD_PTR_Y >> 1) begin
			if (wr_addr[0]) yreg_reg[15:8] <= wr_data; else yreg_reg[7:0] <= wr_data;
		end
		if (wr_en && wr_addr[4:1] == `CSD_PTR_Z >> 1) begin
			if (wr_addr[0]) zreg_reg[15:8] <= wr_data; else zreg_reg[7:0] <= wr_data;
		end
	end
end

endmodule // csd_core

// >>> test/csd_core_monitor.sv
// Port checker for the core datapath: status bits, interrupt entry, self-write guard.
// Assumes one clock and a synchronous active-high reset; bound to csd_core.
`timescale 1ns/10ps

module csd_core_monitor (
	// Clock and reset
	input logic clk,
	input logic rst,
	// Straps and fetch
	input logic rww_variant,
	input logic large_flash,
	input logic [15:0] prog_addr,
	// Interrupts
	input logic [15:0] irq_pending,
	input logic [3:0] irq_ack_num,
	input logic irq_ack,
	// Data side and flash write
	input logic data_we,
	input logic flash_write_refused,
	// Status
	input logic [7:0] processor_status_flags
);
	// ********************
	// Helpers and checks
	// ********************
	logic [15:0] vec_words;
	logic [15:0] below_mask;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Vector slot in words, and the requests that outrank the one served.
	assign vec_words = {12'h000, irq_ack_num} + 16'h0001;
	assign below_mask = (16'h0001 << irq_ack_num) - 16'h0001;
	// Entry drops the global enable, then pushes on the next cycle.
	sequence s_entry;
		irq_ack && !processor_status_flags[7];
	endsequence
	sequence s_push;
		data_we;
	endsequence
	a_reset_status_zero: assert property (
		disable iff (1'b0) rst |=> processor_status_flags == 8'h00)
		else $error("status not zero after reset");
	a_sign_is_xor: assert property (
		processor_status_flags[4] == (processor_status_flags[2] ^ processor_status_flags[3]))
		else $error("sign bit differs from negative xor overflow");
	a_masked_no_ack: assert property (
		irq_ack |-> $past(processor_status_flags[7]))
		else $error("interrupt taken while globally disabled");
	a_ack_clears_gie: assert property (
		irq_ack |-> !processor_status_flags[7])
		else $error("global enable kept on interrupt entry");
	a_entry_push: assert property (
		s_entry |=> s_push)
		else $error("no push after interrupt entry");
	a_lowest_first: assert property (
		irq_ack |-> (($past(irq_pending) & below_mask) == 16'h0000)
		&& (($past(irq_pending) & (below_mask + 16'h0001)) != 16'h0000))
		else $error("served request is not the lowest pending");
	a_vector_spacing: assert property (
		irq_ack |-> prog_addr == (large_flash ? {vec_words[14:0], 1'b0} : vec_words))
		else $error("vector address wrong for spacing");
	a_status_kept: assert property (
		irq_ack |-> processor_status_flags[6:0] == $past(processor_status_flags[6:0]))
		else $error("status bits changed on interrupt entry");
	a_refuse_rww: assert property (
		flash_write_refused |-> rww_variant)
		else $error("self-write refused without boot restriction");
endmodule // csd_core_monitor

bind csd_core csd_core_monitor mon_u (
	.clk(clk), .rst(rst), .rww_variant(rww_variant), .large_flash(large_flash),
	.prog_addr(prog_addr), .irq_pending(irq_pending), .irq_ack_num(irq_ack_num),
	.irq_ack(irq_ack), .data_we(data_we), .flash_write_refused(flash_write_refused),
	.processor_status_flags(processor_status_flags)
);

// >>> test/csd_mem_model.sv
// Behavioural program flash and data memory facing the core datapath.
// Assumes one clock; fetched words and read data arrive one cycle late.
`timescale 1ns/10ps

module csd_mem_model (
	// Clock
	input logic clk,
	// Program side
	input logic [15:0] prog_addr,
	output logic [15:0] prog_data,
	// Data side
	input logic [15:0] data_addr,
	input logic [7:0] data_wdata,
	input logic data_we,
	input logic data_re,
	output logic [7:0] data_rdata,
	output logic [7:0] push_cnt
);
	// ********************
	// Memories
	// ********************
	logic [7:0] sram [0:255];
	initial begin
		prog_data = 16'h0000;
		data_rdata = 8'h00;
		push_cnt = 8'h00;
	end
	// Flash words are a fixed pattern of their address.
	always @(posedge clk) begin
		prog_data <= ~prog_addr;
	end
	// stack in SRAM
	// An idle read port toggles, so a stale value is never mistaken for data.
	always @(posedge clk) begin
		if (data_we) begin
			sram[data_addr[7:0]] <= data_wdata;
			push_cnt <= push_cnt + 8'h01;
		end
		if (data_re)
			data_rdata <= sram[data_addr[7:0]];
		else
			data_rdata <= ~data_rdata;
	end
endmodule // csd_mem_model

// >>> test/tb_cpu_core_status_datapath.sv
// Self-checking bench for the core datapath: ALU flags, bit copy, interrupts, self-write.
// Assumes the memory model answers fetches and takes data writes.
`timescale 1ns/10ps
`include "csd_regs.vh"

module tb_cpu_core_status_datapath;
	// ********************
	// Signals and tables
	// ********************
	logic clk, rst, rww_variant, large_flash, op_use_imm, op_two_word, irq_ack;
	logic data_we, data_re, flash_write_go, flash_write_refused, got_go, got_ref;
	logic [2:0] op_bit;
	logic [3:0] irq_ack_num;
	logic [4:0] op_code, op_dst, op_src;
	logic [7:0] op_imm, data_wdata, data_rdata, processor_status_flags, push_cnt, pc0, st;
	logic [15:0] boot_start, prog_addr, prog_data, irq_pending, data_addr, ptr_x, ptr_y, ptr_z;
	int error_cnt, n_tests;
	// ALU cases: first operand, second register, immediate, result, flags.
	logic [7:0] t_a [5] = '{8'h0F, 8'h7F, 8'h80, 8'hFF, 8'h10};
	logic [7:0] t_b [5] = '{8'h01, 8'h01, 8'h80, 8'h01, 8'hEE};
	logic [7:0] t_i [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
	logic [7:0] t_r [5] = '{8'h10, 8'h80, 8'h00, 8'h00, 8'h0F};
	logic [7:0] t_f [5] = '{8'h20, 8'h2C, 8'h1B, 8'h23, 8'h20};
	// Interrupt cases and self-write cases.
	logic [15:0] q_p [2] = '{16'h0006, 16'h8004};
	logic [15:0] q_v [2] = '{16'h0002, 16'h0006};
	logic [3:0] q_n [2] = '{4'h1, 4'h2};
	logic s_rw [3] = '{1'b1, 1'b1, 1'b0};
	logic [15:0] s_bs [3] = '{16'hFFFF, 16'h0000, 16'hFFFF};
	logic s_ref [3] = '{1'b1, 1'b0, 1'b0};

	csd_core dut_u (.clk, .rst, .rww_variant, .large_flash, .boot_start, .prog_addr,
		.prog_data, .op_code, .op_dst, .op_src, .op_imm, .op_use_imm, .op_bit,
		.op_two_word, .irq_pending, .irq_ack_num, .irq_ack, .data_addr, .data_wdata,
		.data_we, .data_re, .data_rdata, .flash_write_go, .flash_write_refused,
		.ptr_x, .ptr_y, .ptr_z, .processor_status_flags);
	csd_mem_model mem_u (.clk, .prog_addr, .prog_data, .data_addr, .data_wdata,
		.data_we, .data_re, .data_rdata, .push_cnt);

	// Free-running 50 MHz clock.
	initial clk = 1'b0;
	always #10 clk = ~clk;

	// ********************
	// Tasks
	// ********************
	// One decoded operation for one cycle; fields stand until the next call.
	task op(input logic [4:0] c, input logic [4:0] d, input logic [4:0] s,
		input logic [7:0] im, input logic ui, input logic [2:0] b);
		op_code = c;
		op_dst = d;
		op_src = s;
		op_imm = im;
		op_use_imm = ui;
		op_bit = b;
		@(negedge clk);
	endtask
	task ldi(input logic [4:0] d, input logic [7:0] v);
		op(`CSD_OP_LDI, d, d, v, 1'b1, 3'h0);
	endtask
	// A standing ALU code would run again, so idling parks a no-op.
	task idle(input int n);
		op_code = `CSD_OP_NOP;
		repeat (n) @(negedge clk);
	endtask
	task chk16(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk16({15'h0000, got}, {15'h0000, exp});
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard, far beyond the fewer than one hundred cycles the tests need.
	initial begin
		repeat (4000) @(posedge clk);
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		conclude();
	end

	// ********************
	// Test sequence
	// ********************
	initial begin
		rst = 1'b1;
		rww_variant = 1'b0;
		large_flash = 1'b0;
		boot_start = 16'h0000;
		irq_pending = 16'h0000;
		op_two_word = 1'b0;
		error_cnt = 0;
		n_tests = 0;
		op(`CSD_OP_NOP, 5'h00, 5'h00, 8'h00, 1'b0, 3'h0);
		@(negedge clk);
		rst = 1'b0;
		chk16({8'h00, processor_status_flags}, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			ldi(`CSD_PTR_X, t_a[i]);
			ldi(5'h1B, t_b[i]);
			op(i < 4 ? `CSD_OP_ADD : `CSD_OP_SUB, `CSD_PTR_X, 5'h1B, t_i[i], i == 4, 3'h0);
			idle(2);
			chk16(ptr_x, {t_b[i], t_r[i]});
			chk16({8'h00, processor_status_flags}, {8'h00, t_f[i]});
		end
		$display("test alu done");
		ldi(`CSD_PTR_Z, 8'h04);
		ldi(5'h1F, 8'h01);
		op(`CSD_OP_BST, `CSD_PTR_Z, `CSD_PTR_Z, 8'h00, 1'b0, 3'h2);
		op(`CSD_OP_BLD, 5'h1F, 5'h1F, 8'h00, 1'b0, 3'h7);
		idle(2);
		chk1(processor_status_flags[`CSD_ST_CPY], 1'b1);
		chk16(ptr_z, 16'h8104);
		$display("test bit copy done");
		for (int i = 0; i < 2; i++) begin
			large_flash = i[0];
			irq_pending = q_p[i];
			pc0 = push_cnt;
			st = processor_status_flags;
			idle(4);
			chk16({8'h00, push_cnt}, {8'h00, pc0});
			op(`CSD_OP_SEI, 5'h00, 5'h00, 8'h00, 1'b0, 3'h0);
			idle(0);
			for (int k = 0; k < 8 && irq_ack !== 1'b1; k++) @(negedge clk);
			chk1(irq_ack, 1'b1);
			chk16({12'h000, irq_ack_num}, {12'h000, q_n[i]});
			chk16(prog_addr, q_v[i]);
			chk16({8'h00, processor_status_flags}, {8'h00, st});
			irq_pending = 16'h0000;
			idle(2);
			chk1(push_cnt !== pc0, 1'b1);
			op(`CSD_OP_INTERRUPT_RETURN_INSTR, 5'h00, 5'h00, 8'h00, 1'b0, 3'h0);
			idle(2);
			chk1(processor_status_flags[`CSD_ST_GIE], 1'b1);
			op(`CSD_OP_CLI, 5'h00, 5'h00, 8'h00, 1'b0, 3'h0);
			idle(2);
			chk1(processor_status_flags[`CSD_ST_GIE], 1'b0);
		end
		$display("test interrupts done");
		for (int i = 0; i < 3; i++) begin
			rww_variant = s_rw[i];
			boot_start = s_bs[i];
			op(`CSD_OP_SPM, 5'h00, 5'h00, 8'h00, 1'b0, 3'h0);
			idle(0);
			got_go = 1'b0;
			got_ref = 1'b0;
			repeat (3) begin
				got_go = got_go | flash_write_go;
				got_ref = got_ref | flash_write_refused;
				@(negedge clk);
			end
			chk1(got_ref, s_ref[i]);
			chk1(got_go, !s_ref[i]);
		end
		$display("test self-write done");
		conclude();
	end
endmodule // tb_cpu_core_status_datapath
